/* File: include/isp_pkg.sv */
/*
 Shared constants for the serial memory programming link: instruction
 codes, key bytes, erased value and link timing limits.
 Assumes both ends and the interface compile after this package.
*/
package isp_pkg;
   // ----------------------------------------------------------------
   // Instruction bytes (first byte of each four-byte instruction; the keys are second bytes)
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ENABLE = 8'hAC; // Enable or chip erase family
   localparam logic [7:0] KEY_ENABLE = 8'h53; // Second byte: enable
   localparam logic [7:0] KEY_ERASE = 8'h80; // Second byte: chip erase
   localparam logic [7:0] CMD_WR_EE = 8'hC0; // Write one EEPROM byte
   localparam logic [7:0] CMD_RD_EE = 8'hA0; // Read one EEPROM byte
   localparam logic [7:0] CMD_WR_FL = 8'h40; // Write one flash byte
   localparam logic [7:0] CMD_RD_FL = 8'h20; // Read one flash byte
   localparam logic [7:0] CMD_POLL = 8'hF0; // Read busy flag
   // ----------------------------------------------------------------
   // Data values and word layout
   // ----------------------------------------------------------------
   localparam logic [7:0] ERASED_BYTE = 8'hFF; // Erased memory content
   localparam logic [7:0] IDLE_BYTE = 8'h00; // Reply filler
   localparam int INSTR_BITS = 32; // Bits per instruction
   localparam int BYTE_BITS = 8; // Bits per byte
   localparam int POS_CMD = 24; // Command byte position
   localparam int POS_KEY = 16; // Key or address high position
   localparam int POS_ALO = 8; // Address low position
   localparam int POS_DAT = 0; // Data byte position
   // ----------------------------------------------------------------
   // Serial clock phase limit and reset settle time, in device clock cycles
   // ----------------------------------------------------------------
   localparam int SCK_HALF_MIN = 3; // Device clock at or above 12 MHz
   localparam int SETTLE_CYCLES = 16; // Reset low before first instruction
endpackage

/* File: include/isp_if.sv */
/*
 Serial programming link between programmer and device: serial clock,
 data both ways and the device reset pin.
 Assumes the testbench instantiates it and hands a modport to each end.
*/
`timescale 1ns/1ps
`default_nettype none
interface isp_if;
   logic sck; // Serial clock, made by the programmer
   logic mosi; // Programmer to device data
   logic miso; // Device to programmer data
   logic reset_pin_n; // Device reset pin, low while programming
   // Device end
   modport dev (input sck, input mosi, input reset_pin_n, output miso);
   // Programmer end
   modport prog (output sck, output mosi, output reset_pin_n, input miso);
endinterface
`default_nettype wire

/* File: hdl/isp_device.sv */
/*
 Device end: link shifter on the serial clock, memories on the device clock.
 Assumes long enough serial clock phases and a running device clock.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_device #(
   parameter int FLASH_DEPTH = 8192, // Flash bytes
   parameter int EE_DEPTH = 512, // EEPROM bytes
   parameter int EE_ERASE_CYCLES = 64, // Auto-erase duration
   parameter int EE_PROG_CYCLES = 64 // Program duration
) (
   // Device clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link
   isp_if.dev link,
   // Run-time flash read port
   input wire logic [15:0] flash_rd_addr,
   output logic [7:0] flash_rd_data,
   // Status
   output logic prog_active,
   output logic busy
);
   localparam int FA = $clog2(FLASH_DEPTH);
   localparam int EA = $clog2(EE_DEPTH);

   // Refuse shapes the logic cannot serve
   initial begin
      if (FLASH_DEPTH < EE_DEPTH || FLASH_DEPTH > 65536 || EE_DEPTH < 2) begin
         $error("isp_device: bad memory depths");
      end
      if (EE_ERASE_CYCLES < 1 || EE_PROG_CYCLES < 1) begin
         $error("isp_device: bad write timing");
      end
   end

   // ----------------------------------------------------------------
   // Link domain (serial clock)
   // ----------------------------------------------------------------
   logic link_clr; // Reset pin high: leave programming
   logic [4:0] bit_cnt; // Bits taken in this instruction
   logic [31:0] shift_in; // Incoming bits
   logic [31:0] instr_word; // Last whole instruction
   logic instr_tgl; // Flips once per instruction
   logic [7:0] out_sh; // Outgoing byte
   logic [7:0] reply; // Read result, device clock domain

   // link held clear unless reset pin low
   assign link_clr = link.reset_pin_n;

   // Sample on rising serial clock
   always_ff @(posedge link.sck or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt <= 5'h0;
         shift_in <= 32'h0000_0000;
         instr_word <= 32'h0000_0000;
         instr_tgl <= 1'b0;
      end else begin
         bit_cnt <= bit_cnt + 5'h1;
         shift_in <= {shift_in[30:0], link.mosi};
         // Word holds for the next instruction
         if (bit_cnt == 5'(isp_pkg::INSTR_BITS - 1)) begin
            instr_word <= {shift_in[30:0], link.mosi};
            instr_tgl <= ~instr_tgl;
         end
      end
   end

   // Drive on falling serial clock
   always_ff @(negedge link.sck or posedge link_clr) begin
      if (link_clr) begin
         out_sh <= isp_pkg::IDLE_BYTE;
      end else if (bit_cnt[2:0] == 3'h0) begin
         case (bit_cnt[4:3])
            // Byte four: last read result
            2'h3: out_sh <= reply;
            // Bytes two, three: echo
            2'h1, 2'h2: out_sh <= shift_in[7:0];
            default: out_sh <= isp_pkg::IDLE_BYTE;
         endcase
      end else begin
         out_sh <= {out_sh[6:0], 1'b0};
      end
   end

   assign link.miso = out_sh[7];

   // ----------------------------------------------------------------
   // Crossing into the device clock
   // ----------------------------------------------------------------
   logic tgl_s1, tgl_s2, tgl_s3; // Instruction toggle synchroniser
   logic pin_s1, pin_s2; // Reset pin synchroniser
   logic instr_evt; // One cycle per new instruction

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         tgl_s1 <= instr_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
         pin_s1 <= link.reset_pin_n;
         pin_s2 <= pin_s1;
      end
   end

   assign instr_evt = tgl_s2 ^ tgl_s3;

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   logic [7:0] op, key, alo, dat; // Instruction fields
   logic [15:0] addr; // Full byte address
   logic enabled; // Enable accepted since reset went low

   assign op = instr_word[isp_pkg::POS_CMD +: isp_pkg::BYTE_BITS];
   assign key = instr_word[isp_pkg::POS_KEY +: isp_pkg::BYTE_BITS];
   assign alo = instr_word[isp_pkg::POS_ALO +: isp_pkg::BYTE_BITS];
   assign dat = instr_word[isp_pkg::POS_DAT +: isp_pkg::BYTE_BITS];
   assign addr = {key, alo};

   // Mode follows synced reset pin
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prog_active <= 1'b0;
      end else begin
         prog_active <= ~pin_s2;
      end
   end

   // enable flag, cleared on pin high
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         enabled <= 1'b0;
      end else if (pin_s2) begin
         enabled <= 1'b0;
      end else if (instr_evt && op == isp_pkg::CMD_ENABLE && key == isp_pkg::KEY_ENABLE) begin
         enabled <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Memory engine
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, // Waiting
      ST_ERASE_ALL = 4'b0010, // Chip erase sweep
      ST_EE_ERASE = 4'b0100, // EEPROM auto-erase phase
      ST_EE_PROG = 4'b1000 // EEPROM program phase
   } eng_state_e;

   eng_state_e state; // Engine state
   logic [15:0] cnt; // Sweep index or phase timer
   logic [EA-1:0] ee_addr; // Latched EEPROM target
   logic [7:0] ee_data; // Latched EEPROM data
   logic [7:0] flash_mem [FLASH_DEPTH]; // Program memory
   logic [7:0] ee_mem [EE_DEPTH]; // Data EEPROM
   logic act; // Instruction may act now
   logic last; // Phase ends now

   // act only once enabled and idle
   assign act = instr_evt && enabled && !pin_s2 && state == ST_IDLE;

   always_comb begin
      case (state)
         ST_ERASE_ALL: last = cnt == 16'(FLASH_DEPTH - 1);
         ST_EE_ERASE: last = cnt == 16'(EE_ERASE_CYCLES - 1);
         ST_EE_PROG: last = cnt == 16'(EE_PROG_CYCLES - 1);
         default: last = 1'b0;
      endcase
   end

   // State sequence
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cnt <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               cnt <= 16'h0000;
               if (act && op == isp_pkg::CMD_ENABLE && key == isp_pkg::KEY_ERASE) begin
                  state <= ST_ERASE_ALL;
               end else if (act && op == isp_pkg::CMD_WR_EE) begin
                  state <= ST_EE_ERASE;
               end
            end
            ST_ERASE_ALL, ST_EE_ERASE, ST_EE_PROG: begin
               cnt <= last ? 16'h0000 : cnt + 16'h0001;
               if (last) begin
                  state <= (state == ST_EE_ERASE) ? ST_EE_PROG : ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Latch EEPROM target
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ee_addr <= '0;
         ee_data <= isp_pkg::ERASED_BYTE;
      end else if (act && op == isp_pkg::CMD_WR_EE) begin
         ee_addr <= addr[EA-1:0];
         ee_data <= dat;
      end
   end

   // Flash writes; content survives reset
   always_ff @(posedge clk_sys) begin
      if (state == ST_ERASE_ALL) begin
         flash_mem[cnt[FA-1:0]] <= isp_pkg::ERASED_BYTE;
      end else if (act && op == isp_pkg::CMD_WR_FL) begin
         flash_mem[addr[FA-1:0]] <= dat;
      end
   end

   // EEPROM array writes
   always_ff @(posedge clk_sys) begin
      if (state == ST_ERASE_ALL && cnt < 16'(EE_DEPTH)) begin
         ee_mem[cnt[EA-1:0]] <= isp_pkg::ERASED_BYTE;
      end else if (state == ST_EE_ERASE && cnt == 16'h0000) begin
         ee_mem[ee_addr] <= isp_pkg::ERASED_BYTE;
      end else if (state == ST_EE_PROG && last) begin
         ee_mem[ee_addr] <= ee_data;
      end
   end

   // Read results, sent in the next instruction
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reply <= isp_pkg::IDLE_BYTE;
      end else if (instr_evt && enabled && op == isp_pkg::CMD_POLL) begin
         reply <= {7'h00, state != ST_IDLE};
      end else if (act && op == isp_pkg::CMD_RD_EE) begin
         reply <= ee_mem[addr[EA-1:0]];
      end else if (act && op == isp_pkg::CMD_RD_FL) begin
         reply <= flash_mem[addr[FA-1:0]];
      end
   end

   // Status and run-time read port
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         flash_rd_data <= isp_pkg::ERASED_BYTE;
      end else begin
         busy <= state != ST_IDLE;
         flash_rd_data <= flash_mem[flash_rd_addr[FA-1:0]];
      end
   end
endmodule
`default_nettype wire

/* File: hdl/isp_programmer.sv */
/*
 Programmer end: instruction FIFO, serial clock divider, reset pin.
 Assumes a device clock of 12 MHz or more, running throughout.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_fifo #(
   parameter int WIDTH = 32, // Word width
   parameter int DEPTH = 8 // Entries, power of two
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("isp_fifo: bad depth");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wr_ptr, rd_ptr; // Extra bit tells full from empty

   assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

module isp_programmer #(
   parameter int SCK_HALF = 4, // Clock cycles per serial clock phase
   parameter int FIFO_DEPTH = 8 // Queued instructions
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link
   isp_if.prog link,
   // Session control
   input wire logic prog_en,
   // Instruction queue
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [31:0] cmd_word,
   // Replies
   output logic reply_valid,
   output logic [31:0] reply_word
);
   initial begin
      if (SCK_HALF < isp_pkg::SCK_HALF_MIN + 1 || SCK_HALF > 255) begin
         $error("isp_programmer: bad SCK_HALF");
      end
   end

   typedef enum logic [3:0] {
      PS_OFF = 4'b0001, // Reset pin released
      PS_SETTLE = 4'b0010, // Reset pin low, waiting
      PS_IDLE = 4'b0100, // Ready
      PS_SHIFT = 4'b1000 // Shifting
   } prog_state_e;

   prog_state_e state; // Sequencer state
   logic [7:0] ph_cnt; // Phase and settle timer
   logic [4:0] bit_idx; // Bits sent
   logic [31:0] tx_sh, rx_sh; // Shift registers
   logic [31:0] out_word; // Enable first, then queue
   logic sent_enable; // Enable sent this session
   logic sck, mosi, pin_n; // Link drivers
   logic miso_s1, miso_s2; // miso synchroniser
   logic q_valid, q_take; // FIFO drain side
   logic [31:0] q_word;
   logic half_end; // Phase ends this cycle

   // Queue; a full queue stalls the source
   isp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_word),
      .out_valid(q_valid),
      .out_ready(q_take),
      .out_data(q_word)
   );

   assign q_take = state == PS_IDLE && sent_enable && prog_en;
   assign out_word = sent_enable ? q_word : {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ENABLE, 16'h0000};
   assign half_end = ph_cnt == 8'(SCK_HALF - 1);
   assign link.sck = sck;
   assign link.mosi = mosi;
   assign link.reset_pin_n = pin_n;

   // Returned data synchroniser
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
      end else begin
         miso_s1 <= link.miso;
         miso_s2 <= miso_s1;
      end
   end

   // Sequencer and shifter
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= PS_OFF;
         ph_cnt <= 8'h00;
         bit_idx <= 5'h0;
         tx_sh <= 32'h0000_0000;
         rx_sh <= 32'h0000_0000;
         sent_enable <= 1'b0;
         sck <= 1'b0;
         mosi <= 1'b0;
         pin_n <= 1'b1;
         reply_valid <= 1'b0;
         reply_word <= 32'h0000_0000;
      end else begin
         reply_valid <= 1'b0;
         case (state)
            PS_OFF: begin
               pin_n <= 1'b1;
               sent_enable <= 1'b0;
               ph_cnt <= 8'h00;
               // reset pin low before any instruction
               if (prog_en) begin
                  pin_n <= 1'b0;
                  state <= PS_SETTLE;
               end
            end
            PS_SETTLE: begin
               ph_cnt <= ph_cnt + 8'h01;
               if (ph_cnt == 8'(isp_pkg::SETTLE_CYCLES - 1)) begin
                  ph_cnt <= 8'h00;
                  state <= PS_IDLE;
               end
            end
            PS_IDLE: begin
               ph_cnt <= 8'h00;
               bit_idx <= 5'h0;
               if (!prog_en) begin
                  state <= PS_OFF;
               end else if (!sent_enable || q_valid) begin
                  tx_sh <= out_word;
                  mosi <= out_word[31];
                  sent_enable <= 1'b1;
                  state <= PS_SHIFT;
               end
            end
            PS_SHIFT: begin
               ph_cnt <= half_end ? 8'h00 : ph_cnt + 8'h01;
               if (half_end) begin
                  sck <= ~sck;
                  if (!sck) begin
                     // Rise: data settled since last fall
                     rx_sh <= {rx_sh[30:0], miso_s2};
                  end else begin
                     tx_sh <= {tx_sh[30:0], 1'b0};
                     mosi <= tx_sh[30];
                     bit_idx <= bit_idx + 5'h1;
                     if (bit_idx == 5'(isp_pkg::INSTR_BITS - 1)) begin
                        reply_valid <= 1'b1;
                        reply_word <= rx_sh;
                        state <= PS_IDLE;
                     end
                  end
               end
            end
            default: state <= PS_OFF;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: testbench/isp_link_checker.sv */
/*
 Checks on the link wires and device status.
 Assumes the bench places it beside the link.
*/
`timescale 1ns/1ps
`default_nettype none
module isp_link_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link wires
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic reset_pin_n,
   // Device status
   input wire logic prog_active,
   input wire logic busy
);
   // ------------------------------------------------------------
   // Word capture
   // ------------------------------------------------------------
   logic sck_q; // Serial clock last cycle
   logic [31:0] word; // Bits seen, MSB first
   logic [4:0] bits; // Bits of current word
   logic done; // Whole word seen
   logic en_seen; // Enable word seen
   logic any_seen; // Some word seen
   wire rise = sck && !sck_q; // Rise on this edge

   // Sample at each rise
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sck_q <= 1'b0;
         word <= 32'h0000_0000;
         bits <= 5'h00;
         done <= 1'b0;
      end else begin
         sck_q <= sck;
         done <= rise && (bits == 5'h1f);
         bits <= reset_pin_n ? 5'h00 : bits + 5'(rise);
         word <= rise ? {word[30:0], mosi} : word;
      end
   end

   // Session flags, cleared while the pin is high
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         en_seen <= 1'b0;
         any_seen <= 1'b0;
      end else begin
         en_seen <= !reset_pin_n && (en_seen || (done && word[31:16] ==
            {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ENABLE}));
         any_seen <= !reset_pin_n && (any_seen || done);
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sck_idle_a: assert property (reset_pin_n |-> !sck)
      else $error("clock outside session");
   miso_clear_a: assert property (reset_pin_n && $past(reset_pin_n) |-> !miso)
      else $error("device data not clear");
   miso_edge_a: assert property ($changed(miso) |-> !sck)
      else $error("data moved, clock high");
   sck_low_a: assert property ($fell(sck) |-> !sck [*3])
      else $error("clock low too short");
   sck_high_a: assert property ($rose(sck) |-> sck [*3])
      else $error("clock high too short");
   first_enable_a: assert property (done && !any_seen |->
      word[31:16] == {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ENABLE})
      else $error("first word not enable");
   busy_gate_a: assert property ($rose(busy) |-> en_seen)
      else $error("engine ran unenabled");
   erase_start_a: assert property (done && en_seen && !busy && word[31:16] ==
      {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ERASE} |-> ##[1:10] busy)
      else $error("erase did not start");
   ee_write_a: assert property (done && en_seen && !busy &&
      word[31:24] == isp_pkg::CMD_WR_EE |-> ##[1:10] busy)
      else $error("eeprom write not timed");
   session_a: assert property (!reset_pin_n [*6] |-> prog_active)
      else $error("not programming");
endmodule
`default_nettype wire

/* File: testbench/serial_memory_programming_test.sv */
/*
 Bench: programmer and device on one link, a second device bit-banged.
 Assumes package, interface and design compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_memory_programming_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [31:0] POLL = {isp_pkg::CMD_POLL, 24'h00_0000};
   localparam logic [31:0] EN = {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ENABLE, 16'h0000};
   localparam logic [31:0] ERASE = {isp_pkg::CMD_ENABLE, isp_pkg::KEY_ERASE, 16'h0000};
   logic clk_sys = 1'b0; // Shared clock
   logic nrst = 1'b0; // Reset, low active
   logic prog_en = 1'b0; // Session request
   logic cmd_valid = 1'b0; // Queue push
   logic cmd_ready; // Queue not full
   logic [31:0] cmd_word = 32'h0000_0000; // Word pushed
   logic reply_valid; // Reply strobe
   logic [31:0] reply_word; // Reply bits
   logic [15:0] flash_rd_addr = 16'h0000; // Run-time address
   logic [7:0] flash_rd_data; // Run-time data
   logic prog_active; // Device in session
   logic busy; // Engine running
   logic busy2; // Second engine
   logic [31:0] rq[$]; // Replies in order
   int bad_count = 0; // Mismatches
   int checks_done = 0; // Comparisons
   int cyc = 0; // Cycles run
   isp_if l1();
   isp_if l2();

   isp_programmer #(.SCK_HALF(4), .FIFO_DEPTH(8)) isp_programmer_i (.clk_sys(clk_sys),
      .nrst(nrst), .link(l1), .prog_en(prog_en), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_word(cmd_word), .reply_valid(reply_valid),
      .reply_word(reply_word));
   isp_device #(.FLASH_DEPTH(512)) isp_device_i (.clk_sys(clk_sys), .nrst(nrst),
      .link(l1), .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
      .prog_active(prog_active), .busy(busy));
   isp_device #(.FLASH_DEPTH(512)) isp_device_i2 (.clk_sys(clk_sys), .nrst(nrst),
      .link(l2), .flash_rd_addr(16'h0000), .flash_rd_data(), .prog_active(), .busy(busy2));
   isp_link_checker isp_link_checker_i (.clk_sys(clk_sys), .nrst(nrst), .sck(l1.sck),
      .mosi(l1.mosi), .miso(l1.miso), .reset_pin_n(l1.reset_pin_n),
      .prog_active(prog_active), .busy(busy));

   always #10 clk_sys = ~clk_sys;

   // Collect replies; cut a hang short
   always @(posedge clk_sys) begin
      cyc++;
      if (reply_valid === 1'b1) rq.push_back(reply_word);
      if (cyc == 60000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] op(input logic [7:0] c, input logic [8:0] a,
      input logic [7:0] d);
      return {c, 7'h00, a, d};
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Push a word and wait for its reply
   task automatic send(input logic [31:0] w, output logic [31:0] r);
      int n;
      n = rq.size();
      cmd_word = w;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      while (rq.size() == n) @(negedge clk_sys);
      r = rq[n];
      check("reply lead", 32'h0, 32'(r[31:24]));
      check("reply echo", 32'(w[31:16]), 32'(r[23:8]));
   endtask

   // Busy shows one poll late
   task automatic poll_idle();
      logic [31:0] r;
      send(POLL, r);
      send(POLL, r);
      while (r[0] !== 1'b0) send(POLL, r);
   endtask

   task automatic rd_ee(input logic [8:0] a, output logic [7:0] d);
      logic [31:0] r;
      send(op(isp_pkg::CMD_RD_EE, a, 8'h00), r);
      send(POLL, r);
      d = r[7:0];
   endtask

   // Second link, four cycles a phase
   task automatic bang(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         l2.mosi = w[i];
         repeat (4) @(negedge clk_sys);
         l2.sck = 1'b1;
         repeat (4) @(negedge clk_sys);
         l2.sck = 1'b0;
      end
      repeat (8) @(negedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [8:0] a;
      logic [7:0] d;
      logic [7:0] e;
      int acc;
      int n;
      void'($urandom(32'h6387_06a4));
      l2.sck = 1'b0;
      l2.mosi = 1'b0;
      l2.reset_pin_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      nrst = 1'b1;
      // Second device: pin high, no enable, enabled
      bang(EN);
      bang(ERASE);
      check("busy pin high", 32'h0, 32'(busy2));
      l2.reset_pin_n = 1'b0;
      repeat (isp_pkg::SETTLE_CYCLES) @(negedge clk_sys);
      bang(ERASE);
      check("busy no enable", 32'h0, 32'(busy2));
      bang(EN);
      bang(ERASE);
      check("busy enabled", 32'h1, 32'(busy2));
      // Erase, random cells read erased; enable reply comes first
      prog_en = 1'b1;
      while (rq.size() == 0) @(negedge clk_sys);
      send(ERASE, r);
      poll_idle();
      for (int i = 0; i < 4; i++) begin
         a = 9'($urandom);
         flash_rd_addr = {7'h00, a};
         repeat (2) @(negedge clk_sys);
         check("flash erased", 32'(isp_pkg::ERASED_BYTE), 32'(flash_rd_data));
         rd_ee(a, e);
         check("eeprom erased", 32'(isp_pkg::ERASED_BYTE), 32'(e));
      end
      // Rewrite without erase, corners first
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
         d = 8'($urandom);
         send(op(isp_pkg::CMD_WR_EE, a, d), r);
         repeat (8) @(negedge clk_sys);
         check("eeprom busy", 32'h1, 32'(busy));
         poll_idle();
         send(op(isp_pkg::CMD_WR_EE, a, ~d), r);
         poll_idle();
         rd_ee(a, e);
         check("eeprom rewrite", {24'h0, ~d}, 32'(e));
         send(op(isp_pkg::CMD_WR_FL, a, d), r);
         flash_rd_addr = {7'h00, a};
         repeat (2) @(negedge clk_sys);
         check("flash write", 32'(d), 32'(flash_rd_data));
      end
      // Fill queue until refused, drain
      n = rq.size();
      acc = 0;
      cmd_word = POLL;
      cmd_valid = 1'b1;
      repeat (12) begin
         acc += (cmd_ready === 1'b1) ? 1 : 0;
         @(negedge clk_sys);
      end
      cmd_valid = 1'b0;
      check("queue refuses", 32'h0, 32'(cmd_ready));
      while (rq.size() < n + acc) @(negedge clk_sys);
      repeat (300) @(negedge clk_sys);
      check("reply count", 32'(n + acc), 32'(rq.size()));
      // Close the session
      prog_en = 1'b0;
      repeat (20) @(negedge clk_sys);
      check("session over", 32'h0, 32'(prog_active));
      wrap_up();
   end
endmodule
`default_nettype wire
